// [hdl/mie_mask_ctrl.sv]
// interrupt enable masks, sticky event status and the interrupt line
// assumes event inputs are one-cycle pulses except the dip levels
`timescale 1ns/1ps
module mie_mask_ctrl
  import mie_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire mie_evt_type i_evt,
  output logic [31:0] o_rdata,
  output logic o_irq
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [15:0] idx);
    return a == {idx, 2'b00};
  endfunction

  mie_bus_type bus;
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // address decode
  wire sel_st1 = hit(bus.addr, IDX_STATUS_FIRST);
  wire sel_st2 = hit(bus.addr, IDX_STATUS_SECOND);
  wire sel_en1 = hit(bus.addr, IDX_ENABLE_FIRST);
  wire sel_en2 = hit(bus.addr, IDX_ENABLE_SECOND);
  wire sel_psrc = hit(bus.addr, IDX_PHASE_SRC);
  wire sel_hs = hit(bus.addr, IDX_HARM_SETUP);

  wire wr_st1 = bus.wr && sel_st1;
  wire wr_st2 = bus.wr && sel_st2;
  wire wr_en1 = bus.wr && sel_en1;
  wire wr_en2 = bus.wr && sel_en2;
  wire wr_hs = bus.wr && sel_hs;

  // registers
  logic [FIRST_W-1:0] en1_q, st1_q, st1_d;
  logic [SECOND_W-1:0] en2_q, st2_q, st2_d;
  logic [HS_W-1:0] hs_q;
  logic [2:0] dip_q, hi_i_src_q, hi_v_src_q;
  logic rst_seen_q;
  logic [31:0] rdata_d, rdata_q;
  logic harm_ready;

  // the timer restarts on the write itself, so it must see the new setup
  wire [HS_W-1:0] hs_cur =
    wr_hs ? (bus.wdata[HS_W-1:0] & HS_WMASK) : hs_q;

  // harmonic refresh timer
  mie_harm_timer u_harm (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_setup(wr_hs),
    .i_first_sel(hs_cur[HS_SEL]),
    .i_period(hs_cur[HS_PERIOD_LSB +: 3]),
    .i_settle(hs_cur[HS_SETTLE_LSB +: 2]),
    .o_ready(harm_ready)
  );

  // dip state change per phase
  logic [2:0] dip_chg;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_dip
      assign dip_chg[g] = i_evt.dip[g] ^ dip_q[g];
    end
  endgenerate

  // reset completion shows once, on the first cycle out of reset
  wire rst_done_evt = !rst_seen_q;

  // event vectors in status layout
  wire [FIRST_W-1:0] set1 = {harm_ready, i_evt.sum3_flip};
  wire [SECOND_W-1:0] set2 = {
    |i_evt.hi_v,
    |i_evt.hi_i,
    |dip_chg,
    rst_done_evt,
    i_evt.amp_zx,
    i_evt.volt_zx,
    i_evt.amp_to,
    i_evt.volt_to,
    i_evt.idle
  };

  wire [FIRST_W-1:0] clr1 =
    wr_st1 ? bus.wdata[FIRST_LSB +: FIRST_W] : '0;
  wire [SECOND_W-1:0] clr2 = wr_st2 ? bus.wdata[SECOND_W-1:0] : '0;

  // set wins over a write-one clear in the same cycle
  assign st1_d = (st1_q & ~clr1) | set1;
  assign st2_d = (st2_q & ~clr2) | set2;

  // the reset-complete bit ignores its mask bit
  logic [SECOND_W-1:0] en2_eff;
  always_comb begin
    en2_eff = en2_q;
    en2_eff[S_RESET_COMPLETE_EVENT] = 1'b1;
  end

  assign o_irq = |(st1_q & en1_q) | |(st2_q & en2_eff);

  // read mux; unmapped addresses read zero
  wire [31:0] rd_st1 = {12'h000, st1_q, 18'h00000};
  wire [31:0] rd_en1 = {12'h000, en1_q, 18'h00000};
  wire [31:0] rd_st2 = {13'h0000, st2_q};
  wire [31:0] rd_en2 = {13'h0000, en2_q};
  wire [31:0] rd_psrc = {17'h00000, dip_q, hi_v_src_q, 3'h0,
                         hi_i_src_q, 3'h0};
  wire [31:0] rd_hs = {24'h000000, hs_q};

  always_comb begin
    rdata_d = RST_WORD;
    if (sel_st1) rdata_d = rd_st1;
    if (sel_en1) rdata_d = rd_en1;
    if (sel_st2) rdata_d = rd_st2;
    if (sel_en2) rdata_d = rd_en2;
    if (sel_psrc) rdata_d = rd_psrc;
    if (sel_hs) rdata_d = rd_hs;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en1_q <= '0;
      en2_q <= '0;
      st1_q <= '0;
      st2_q <= '0;
      hs_q <= '0;
      rst_seen_q <= 1'b0;
      rdata_q <= RST_WORD;
    end else begin
      // reserved upper bits are simply not stored
      if (wr_en1) en1_q <= bus.wdata[FIRST_LSB +: FIRST_W];
      if (wr_en2) en2_q <= bus.wdata[SECOND_W-1:0];
      if (wr_hs) hs_q <= bus.wdata[HS_W-1:0] & HS_WMASK;
      st1_q <= st1_d;
      st2_q <= st2_d;
      rst_seen_q <= 1'b1;
      rdata_q <= bus.rd ? rdata_d : RST_WORD;
    end
  end

  // phase sources: dip level follows the detector, high sources latch
  // the phases of the latest event so software sees who caused it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dip_q <= '0;
      hi_i_src_q <= '0;
      hi_v_src_q <= '0;
    end else begin
      dip_q <= i_evt.dip;
      if (|i_evt.hi_i) hi_i_src_q <= i_evt.hi_i;
      if (|i_evt.hi_v) hi_v_src_q <= i_evt.hi_v;
    end
  end

  assign o_rdata = rdata_q;

  // checks
  a_reset_complete_event_irq: assert property (
    @(posedge i_clk) $fell(i_rst) |-> ##1 o_irq)
    else $error("reset completion did not raise irq");
  a_sum3_sets: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.sum3_flip |=> st1_q[F_SUM3])
    else $error("sign flip event lost");
  a_sum3_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.sum3_flip && en1_q[F_SUM3] && !wr_en1 |=> o_irq)
    else $error("enabled sign flip gave no irq");
  a_hready_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    harm_ready && en1_q[F_HREADY] && !wr_en1 |=> o_irq)
    else $error("enabled harmonic ready gave no irq");
  a_en1_rsvd: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_rd && sel_en1 |=> o_rdata[31:20] == 12'h000)
    else $error("reserved first-mask bits read nonzero");
  a_idle_total: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.idle[0] |=> st2_q[S_IDLE_LSB])
    else $error("total idle event lost");
  a_vto_phase: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.volt_to[2] |=> st2_q[S_VTO_LSB + 2])
    else $error("missing voltage crossing lost");
  a_azx_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.amp_zx[1] && en2_q[S_AZX_LSB + 1] && !wr_en2 |=> o_irq)
    else $error("current crossing gave no irq");
  a_dip_event: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.dip != $past(i_evt.dip) |=> st2_q[S_DIP])
    else $error("dip change raised no event");
  a_hi_i_src: assert property (
    @(posedge i_clk) disable iff (i_rst)
    |i_evt.hi_i |=> hi_i_src_q == $past(i_evt.hi_i)
      && st2_q[S_HI_I])
    else $error("high current source not reported");
  a_hi_v_src: assert property (
    @(posedge i_clk) disable iff (i_rst)
    |i_evt.hi_v |=> hi_v_src_q == $past(i_evt.hi_v))
    else $error("high voltage source not reported");
  a_masked_quiet: assert property (
    @(posedge i_clk) disable iff (i_rst)
    en1_q == '0 && en2_q == '0 && !st2_q[S_RESET_COMPLETE_EVENT] |-> !o_irq)
    else $error("irq with every mask clear");
  a_set_beats_clr: assert property (
    @(posedge i_clk) disable iff (i_rst)
    wr_st2 && i_evt.volt_zx[0] |=> st2_q[S_VZX_LSB])
    else $error("crossing lost during clear");

  // capture of the remaining event bits into status
  a_idle_fund: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.idle[1] |=> st2_q[S_IDLE_LSB + 1])
    else $error("fundamental idle event lost");
  a_idle_appar: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.idle[2] |=> st2_q[S_IDLE_LSB + 2])
    else $error("apparent idle event lost");
  a_ato_phase: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.amp_to[0] |=> st2_q[S_ATO_LSB])
    else $error("missing current crossing lost");
  a_vzx_phase: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.volt_zx[2] |=> st2_q[S_VZX_LSB + 2])
    else $error("voltage crossing lost");
  a_azx_phase: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.amp_zx[0] |=> st2_q[S_AZX_LSB])
    else $error("current crossing lost");
  a_hi_v_sets: assert property (
    @(posedge i_clk) disable iff (i_rst)
    |i_evt.hi_v |=> st2_q[S_HI_V])
    else $error("high voltage event lost");
  a_hready_sets: assert property (
    @(posedge i_clk) disable iff (i_rst)
    harm_ready |=> st1_q[F_HREADY])
    else $error("harmonic ready event lost");

  // an enabled event raises the line on the next cycle
  a_idle_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.idle[1] && en2_q[S_IDLE_LSB + 1] && !wr_en2 |=> o_irq)
    else $error("fundamental idle gave no irq");
  a_appar_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.idle[2] && en2_q[S_IDLE_LSB + 2] && !wr_en2 |=> o_irq)
    else $error("apparent idle gave no irq");
  a_vto_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.volt_to[0] && en2_q[S_VTO_LSB] && !wr_en2 |=> o_irq)
    else $error("missing voltage crossing gave no irq");
  a_ato_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.amp_to[2] && en2_q[S_ATO_LSB + 2] && !wr_en2 |=> o_irq)
    else $error("missing current crossing gave no irq");
  a_vzx_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.volt_zx[1] && en2_q[S_VZX_LSB + 1] && !wr_en2 |=> o_irq)
    else $error("voltage crossing gave no irq");
  a_dip_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_evt.dip != $past(i_evt.dip) && en2_q[S_DIP] && !wr_en2 |=> o_irq)
    else $error("dip change gave no irq");
  a_hi_i_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    |i_evt.hi_i && en2_q[S_HI_I] && !wr_en2 |=> o_irq)
    else $error("high current gave no irq");
  a_hi_v_irq: assert property (
    @(posedge i_clk) disable iff (i_rst)
    |i_evt.hi_v && en2_q[S_HI_V] && !wr_en2 |=> o_irq)
    else $error("high voltage gave no irq");

  // mask bit 15 is storage only; reset completion is never hidden
  a_reset_complete_event_unmask: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st2_q[S_RESET_COMPLETE_EVENT] |-> o_irq)
    else $error("reset completion masked");
  a_en2_bit15: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_rd && sel_en2 |=> o_rdata[S_RESET_COMPLETE_EVENT] == $past(en2_q[S_RESET_COMPLETE_EVENT]))
    else $error("second-mask bit 15 not stored");

  // status is sticky until software writes a one
  a_sticky_status: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st2_q[S_VTO_LSB] && !wr_st2 |=> st2_q[S_VTO_LSB])
    else $error("status bit dropped without a clear");
  a_sticky_ready: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st1_q[F_HREADY] && !wr_st1 |=> st1_q[F_HREADY])
    else $error("harmonic ready status dropped");
  a_clear_status: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st2_q[S_AZX_LSB] && wr_st2 && bus.wdata[S_AZX_LSB]
      && !i_evt.amp_zx[0] |=> !st2_q[S_AZX_LSB])
    else $error("write of one did not clear status");
  a_irq_source: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_irq |-> (st1_q & en1_q) != '0 || (st2_q & en2_q) != '0
      || st2_q[S_RESET_COMPLETE_EVENT])
    else $error("irq without an enabled flag");

  // phase source register contents
  a_hi_i_keep: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !(|i_evt.hi_i) |=> $stable(hi_i_src_q))
    else $error("high current source changed with no event");
  a_psrc_dip: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_rd && sel_psrc |=> o_rdata[P_DIP_LSB +: 3] == $past(dip_q))
    else $error("dip phases read back wrong");
  a_psrc_hi_v: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_rd && sel_psrc |=> o_rdata[P_HI_V_LSB +: 3] == $past(hi_v_src_q))
    else $error("high voltage phases read back wrong");
  a_psrc_hi_i: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_rd && sel_psrc |=> o_rdata[P_HI_I_LSB +: 3] == $past(hi_i_src_q))
    else $error("high current phases read back wrong");

  c_reset_complete_event: cover property (@(posedge i_clk) disable iff (i_rst)
    st2_q[S_RESET_COMPLETE_EVENT] ##1 wr_st2 ##1 !st2_q[S_RESET_COMPLETE_EVENT]);
  c_hready: cover property (@(posedge i_clk) disable iff (i_rst)
    harm_ready && en1_q[F_HREADY]);
  c_dip: cover property (@(posedge i_clk) disable iff (i_rst)
    st2_q[S_DIP] && en2_q[S_DIP] && o_irq);
  c_set_wins: cover property (@(posedge i_clk) disable iff (i_rst)
    wr_st2 && bus.wdata[S_VZX_LSB] && i_evt.volt_zx[0]);
  c_hi_v: cover property (@(posedge i_clk) disable iff (i_rst)
    |i_evt.hi_v && en2_q[S_HI_V]);

endmodule

// [hdl/mie_pkg.sv]
// package for the meter interrupt enable masks block
// assumes one 20 MHz clock and a word-index register map
package mie_pkg;

  // clock and harmonic timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 125000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 12;
  localparam int HCNT_W = 16;
  localparam logic [HCNT_W-1:0] SETTLE_UNIT_TICKS = 16'h0008;

  // register indices; the byte address is four times the index
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_STATUS_FIRST = 16'he502;
  localparam logic [15:0] IDX_STATUS_SECOND = 16'he503;
  localparam logic [15:0] IDX_ENABLE_FIRST = 16'he50a;
  localparam logic [15:0] IDX_ENABLE_SECOND = 16'he50b;
  localparam logic [15:0] IDX_PHASE_SRC = 16'he600;
  localparam logic [15:0] IDX_HARM_SETUP = 16'he900;

  // first mask and first status: only the upper event bits live here
  localparam int FIRST_LSB = 18;
  localparam int FIRST_W = 2;
  localparam int F_SUM3 = 0;
  localparam int F_HREADY = 1;

  // second mask and second status layout
  localparam int SECOND_W = 19;
  localparam int S_IDLE_LSB = 0;
  localparam int S_VTO_LSB = 3;
  localparam int S_ATO_LSB = 6;
  localparam int S_VZX_LSB = 9;
  localparam int S_AZX_LSB = 12;
  localparam int S_RESET_COMPLETE_EVENT = 15;
  localparam int S_DIP = 16;
  localparam int S_HI_I = 17;
  localparam int S_HI_V = 18;

  // phase event source layout
  localparam int P_HI_I_LSB = 3;
  localparam int P_HI_V_LSB = 9;
  localparam int P_DIP_LSB = 12;

  // harmonic setup layout
  localparam int HS_W = 8;
  localparam int HS_SEL = 0;
  localparam int HS_SETTLE_LSB = 3;
  localparam int HS_PERIOD_LSB = 5;
  localparam logic [HS_W-1:0] HS_WMASK = 8'hf9;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic sum3_flip;
    logic [2:0] idle;
    logic [2:0] volt_to;
    logic [2:0] amp_to;
    logic [2:0] volt_zx;
    logic [2:0] amp_zx;
    logic [2:0] dip;
    logic [2:0] hi_i;
    logic [2:0] hi_v;
  } mie_evt_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mie_bus_type;

  typedef enum logic [1:0] {
    HT_SETTLE = 2'b00,
    HT_RUN = 2'b01
  } mie_ht_state_type;

endpackage

// [hdl/mie_harm_timer.sv]
// harmonic output refresh timer: emits one ready pulse per update
// assumes a restart pulse whenever harmonic setup is written
`timescale 1ns/1ps
module mie_harm_timer
  import mie_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_setup,
  input wire logic i_first_sel,
  input wire logic [2:0] i_period,
  input wire logic [1:0] i_settle,
  output logic o_ready
);

  function automatic logic [HCNT_W-1:0] period_ticks(input logic [2:0] c);
    return HCNT_W'(1) << c;
  endfunction

  function automatic logic [HCNT_W-1:0] settle_ticks(input logic [1:0] c);
    return HCNT_W'((HCNT_W'(c) + HCNT_W'(1)) * SETTLE_UNIT_TICKS);
  endfunction

  mie_ht_state_type st_q, st_d;
  logic [TICK_W-1:0] div_q;
  logic [HCNT_W-1:0] cnt_q, cnt_d;
  logic ready_d, ready_q;
  wire tick = (div_q == TICK_W'(TICK_CYCLES - 1));
  wire expire = tick && (cnt_q == '0);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ready_d = 1'b0;
    if (i_setup) begin
      // a set select skips the settling wait entirely
      st_d = i_first_sel ? HT_RUN : HT_SETTLE;
      // the last settle tick is spent in run, so the first ready lands
      // on the settle time itself and never inside the settle state
      cnt_d = i_first_sel ? period_ticks(i_period) - 1'b1
                          : settle_ticks(i_settle) - HCNT_W'(2);
    end else if (tick) begin
      cnt_d = cnt_q - 1'b1;
      case (st_q)
        HT_SETTLE: begin
          if (expire) begin
            st_d = HT_RUN;
            cnt_d = '0;
          end
        end
        HT_RUN: begin
          if (expire) begin
            ready_d = 1'b1;
            cnt_d = period_ticks(i_period) - 1'b1;
          end
        end
        default: st_d = HT_SETTLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= HT_SETTLE;
      cnt_q <= SETTLE_UNIT_TICKS - HCNT_W'(2);
      div_q <= '0;
      ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      div_q <= (tick || i_setup) ? '0 : div_q + 1'b1;
      ready_q <= ready_d;
    end
  end

  assign o_ready = ready_q;

  a_harm_direct: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_setup && i_first_sel |=> st_q == HT_RUN)
    else $error("direct harmonic start did not enter run");
  a_harm_settle: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_setup && !i_first_sel |=> st_q == HT_SETTLE)
    else $error("harmonic settle wait was skipped");
  a_harm_no_ready_settle: assert property (
    @(posedge i_clk) disable iff (i_rst)
    st_q == HT_SETTLE |=> !o_ready)
    else $error("harmonic ready during settle");

endmodule

// [test/mie_mask_ctrl_tb_top.sv]
// self-checking bench for the interrupt enable mask block
// assumes the register map and event struct of mie_pkg
`timescale 1ns/1ps
module mie_mask_ctrl_tb_top;
  import mie_pkg::*;
  localparam int LIMIT = 30000;
  logic i_clk;
  logic i_rst;
  logic i_wr;
  logic i_rd;
  logic [ADDR_W-1:0] i_addr;
  logic [31:0] i_wdata;
  logic [31:0] o_rdata;
  mie_evt_type i_evt;
  mie_evt_type e;
  logic o_irq;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int ph;

  mie_mask_ctrl uut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_evt(i_evt),
    .o_rdata(o_rdata),
    .o_irq(o_irq)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic irq(input logic exp);
    chk({31'h0, o_irq}, {31'h0, exp});
  endtask

  // one idle cycle between strobes so no signal is driven twice per step
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= {idx, 2'b00};
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= {idx, 2'b00};
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  task automatic pulse(input mie_evt_type p);
    @(posedge i_clk);
    i_evt <= p;
    @(posedge i_clk);
    i_evt <= '0;
    #1;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_evt = '0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    irq(1'b1);
    rdc(IDX_STATUS_SECOND, 32'h0000_8000);
    rdc(IDX_ENABLE_SECOND, 32'h0);
    rdc(IDX_ENABLE_FIRST, 32'h0);
    wr(IDX_ENABLE_SECOND, 32'h0000_8000);
    rdc(IDX_ENABLE_SECOND, 32'h0000_8000);
    wr(IDX_STATUS_SECOND, 32'h0000_8000);
    irq(1'b0);
    $display("test reset_complete done");

    wr(IDX_ENABLE_SECOND, 32'hffff_ffff);
    rdc(IDX_ENABLE_SECOND, 32'h0007_ffff);
    wr(IDX_ENABLE_FIRST, 32'hffff_ffff);
    rdc(IDX_ENABLE_FIRST, 32'h000c_0000);
    rdc(16'h1234, 32'h0);
    irq(1'b0);
    wr(IDX_ENABLE_SECOND, 32'h0);
    wr(IDX_ENABLE_FIRST, 32'h0);
    $display("test mask_access done");

    // each second-status event but reset completion and dip is seen in status while masked, then gated by its bit
    for (int b = 0; b < 19; b++) begin
      if (b == 15 || b == 16)
        continue;
      e = '0;
      ph = b % 3;
      case (b / 3)
        0: e.idle[ph] = 1'b1;
        1: e.volt_to[ph] = 1'b1;
        2: e.amp_to[ph] = 1'b1;
        3: e.volt_zx[ph] = 1'b1;
        4: e.amp_zx[ph] = 1'b1;
        default: begin
          if (b == 17)
            e.hi_i[ph] = 1'b1;
          else
            e.hi_v[ph] = 1'b1;
        end
      endcase
      pulse(e);
      rdc(IDX_STATUS_SECOND, 32'h1 << b);
      irq(1'b0);
      if (b == 17)
        rdc(IDX_PHASE_SRC, 32'h0000_0020);
      // high current source from b == 17 is held, not cleared
      if (b == 18)
        rdc(IDX_PHASE_SRC, 32'h0000_0220);
      wr(IDX_ENABLE_SECOND, 32'h1 << b);
      irq(1'b1);
      wr(IDX_STATUS_SECOND, 32'h1 << b);
      irq(1'b0);
      pulse(e);
      irq(1'b1);
      wr(IDX_STATUS_SECOND, 32'h1 << b);
      irq(1'b0);
      wr(IDX_ENABLE_SECOND, 32'h0);
    end
    $display("test event_gating done");

    // dip is a level: only its changes raise the event
    wr(IDX_ENABLE_SECOND, 32'h0001_0000);
    @(posedge i_clk);
    i_evt.dip <= 3'b010;
    repeat (3) @(posedge i_clk);
    #1;
    irq(1'b1);
    rdc(IDX_PHASE_SRC, 32'h0000_2220);
    wr(IDX_STATUS_SECOND, 32'h0001_0000);
    irq(1'b0);
    @(posedge i_clk);
    i_evt.dip <= 3'b000;
    repeat (3) @(posedge i_clk);
    #1;
    irq(1'b1);
    rdc(IDX_PHASE_SRC, 32'h0000_0220);
    wr(IDX_STATUS_SECOND, 32'h0001_0000);
    wr(IDX_ENABLE_SECOND, 32'h0);
    $display("test dip done");

    // an event in the cycle of its own clear must survive
    e = '0;
    e.volt_zx[0] = 1'b1;
    pulse(e);
    @(posedge i_clk);
    i_addr <= {IDX_STATUS_SECOND, 2'b00};
    i_wdata <= 32'h0000_0200;
    i_wr <= 1'b1;
    i_evt <= e;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_evt <= '0;
    #1;
    rdc(IDX_STATUS_SECOND, 32'h0000_0200);
    wr(IDX_STATUS_SECOND, 32'h0000_0200);
    rdc(IDX_STATUS_SECOND, 32'h0);
    $display("test set_wins done");

    wr(IDX_ENABLE_FIRST, 32'h0004_0000);
    e = '0;
    e.sum3_flip = 1'b1;
    pulse(e);
    irq(1'b1);
    rdc(IDX_STATUS_FIRST, 32'h0004_0000);
    wr(IDX_STATUS_FIRST, 32'h0004_0000);
    irq(1'b0);
    $display("test sum_flip done");

    // select 1, period code 0: first ready one tick after setup
    wr(IDX_HARM_SETUP, 32'h0000_0001);
    wr(IDX_STATUS_FIRST, 32'h0008_0000);
    wr(IDX_ENABLE_FIRST, 32'h0008_0000);
    repeat (2350) @(posedge i_clk);
    #1;
    irq(1'b0);
    repeat (200) @(posedge i_clk);
    #1;
    irq(1'b1);
    rdc(IDX_HARM_SETUP, 32'h0000_0001);
    // select 0, settle code 0: first ready after eight ticks
    wr(IDX_HARM_SETUP, 32'h0);
    wr(IDX_STATUS_FIRST, 32'h0008_0000);
    repeat (2600) @(posedge i_clk);
    #1;
    irq(1'b0);
    repeat (17550) @(posedge i_clk);
    #1;
    irq(1'b1);
    $display("test harmonic done");
    end_of_test();
  end
endmodule
